/* File: rtl/spi_target_frame_timing.sv */
// serial target port: sampling, launch, output enable, timeouts, wake delays
`timescale 1ns/1ps
`default_nettype none
module spi_target_frame_timing
#(
  parameter int unsigned TIMEOUT_CYC = spi_target_pkg::SELECT_LOW_TIMEOUT_CYC,
  parameter int unsigned PUMP_CYC = spi_target_pkg::PUMP_STAGE_READY_DELAY_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frameSelectLow,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic wakeRequest,
  input wire logic [spi_target_pkg::FRAME_BITS-1:0] replyData,
  output logic serialOut,
  output logic serialOutEn,
  output spi_target_pkg::command_t command,
  output logic selectTimeout,
  output logic portReady,
  output logic pumpStageReady
);
  import spi_target_pkg::*;

  // ========================================================================
  // input edge detection; pins are taken as synchronous to clk
  logic sclkReg, sclkNext, selReg, selNext;
  logic sclkRise, sclkFall, selFall, selRise;

  always_comb
  begin
    sclkNext = serialClock;
    selNext = frameSelectLow;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkReg <= 1'b0;
      selReg <= 1'b1;
    end
    else
    begin
      sclkReg <= sclkNext;
      selReg <= selNext;
    end
  end

  assign sclkRise = serialClock & ~sclkReg;
  assign sclkFall = ~serialClock & sclkReg;
  assign selFall = ~frameSelectLow & selReg;
  assign selRise = frameSelectLow & ~selReg;

  // ========================================================================
  // power sequencing: standby, waking, active
  power_state_t stateReg, stateNext;
  logic [31:0] wakeCntReg, wakeCntNext;
  logic portReadyReg, portReadyNext, pumpReadyReg, pumpReadyNext;

  // both ready flags count from the same wake start
  always_comb
  begin
    stateNext = stateReg;
    wakeCntNext = wakeCntReg;
    portReadyNext = portReadyReg;
    pumpReadyNext = pumpReadyReg;
    unique case (stateReg)
      ST_STANDBY:
      begin
        portReadyNext = 1'b0;
        pumpReadyNext = 1'b0;
        wakeCntNext = 32'h00000000;
        if (wakeRequest)
          stateNext = ST_WAKING;
      end
      ST_WAKING:
      begin
        wakeCntNext = wakeCntReg + 32'h00000001;
        if (wakeCntReg + 32'h00000001 >= 32'(PORT_READY_CYC))
          portReadyNext = 1'b1;
        if (wakeCntReg + 32'h00000001 >= 32'(PUMP_CYC))
        begin
          pumpReadyNext = 1'b1;
          stateNext = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (!wakeRequest)
          stateNext = ST_STANDBY;
      end
    endcase
    // dropping the wake request leaves active mode at once, so the ready
    // flags fall with it instead of trailing the state by a cycle
    if (!wakeRequest)
    begin
      stateNext = ST_STANDBY;
      wakeCntNext = 32'h00000000;
      portReadyNext = 1'b0;
      pumpReadyNext = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= ST_STANDBY;
      wakeCntReg <= 32'h00000000;
      portReadyReg <= 1'b0;
      pumpReadyReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      wakeCntReg <= wakeCntNext;
      portReadyReg <= portReadyNext;
      pumpReadyReg <= pumpReadyNext;
    end
  end

  assign portReady = portReadyReg;
  assign pumpStageReady = pumpReadyReg;

  // ========================================================================
  // frame shifting, output launch and command commit
  logic [FRAME_BITS-1:0] rxReg, rxNext, txReg, txNext;
  logic [7:0] bitCntReg, bitCntNext;
  logic doReg, doNext, doEnReg, doEnNext;
  logic [31:0] lowCntReg, lowCntNext;
  logic abortReg, abortNext, toReg, toNext;
  command_t cmdReg, cmdNext;
  logic inFrame;

  // frames are ignored until the port is ready; a frame open at wake-up
  // is picked up mid-frame once the port is ready, without the start-of-frame reset
  // of shift registers, bit count and abort, and with the output enabled from then on
  assign inFrame = ~frameSelectLow & portReadyReg;

  always_comb
  begin
    rxNext = rxReg;
    txNext = txReg;
    bitCntNext = bitCntReg;
    doNext = doReg;
    doEnNext = inFrame;
    lowCntNext = 32'h00000000;
    abortNext = abortReg;
    toNext = 1'b0;
    cmdNext = cmdReg;
    cmdNext.valid = 1'b0;
    if (selFall && portReadyReg)
    begin
      rxNext = SHIFT_RESET;
      bitCntNext = 8'h00;
      abortNext = 1'b0;
      txNext = {replyData[FRAME_BITS-2:0], 1'b0};
      doNext = replyData[FRAME_BITS-1];
    end
    else if (inFrame)
    begin
      if (sclkRise && !abortReg)
      begin
        rxNext = {rxReg[FRAME_BITS-2:0], serialIn};
        bitCntNext = bitCntReg + 8'h01;
      end
      if (sclkFall && !abortReg)
      begin
        doNext = txReg[FRAME_BITS-1];
        txNext = {txReg[FRAME_BITS-2:0], 1'b0};
      end
      // counter saturates: the flag pulses once per stuck frame
      lowCntNext = lowCntReg;
      if (!abortReg)
      begin
        lowCntNext = lowCntReg + 32'h00000001;
        if (lowCntReg + 32'h00000001 >= 32'(TIMEOUT_CYC))
        begin
          toNext = 1'b1;
          abortNext = 1'b1;
        end
      end
    end
    // a command only ever takes effect on the closing edge
    if (selRise && portReadyReg && !abortReg
        && bitCntReg == 8'(FRAME_BITS))
    begin
      cmdNext.valid = 1'b1;
      cmdNext.data = rxReg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxReg <= SHIFT_RESET;
      txReg <= SHIFT_RESET;
      bitCntReg <= 8'h00;
      doReg <= 1'b0;
      doEnReg <= 1'b0;
      lowCntReg <= 32'h00000000;
      abortReg <= 1'b0;
      toReg <= 1'b0;
      cmdReg <= '0;
    end
    else
    begin
      rxReg <= rxNext;
      txReg <= txNext;
      bitCntReg <= bitCntNext;
      doReg <= doNext;
      doEnReg <= doEnNext;
      lowCntReg <= lowCntNext;
      abortReg <= abortNext;
      toReg <= toNext;
      cmdReg <= cmdNext;
    end
  end

  assign serialOut = doReg;
  assign serialOutEn = doEnReg;
  assign selectTimeout = toReg;
  assign command = cmdReg;
endmodule
`default_nettype wire

/* File: rtl/spi_target_pkg.sv */
// constants and carrier types for the serial target frame timing block
// ==========================================================================
// Contract
// - The controller uses polarity 0 and phase 0 and the device captures input bits on clock rise.
// - The device launches each output bit on the falling clock edge; the code launches the first bit at frame select fall.
// - The device flags a timeout after frame select stays low for 20 to 50 ms, typically 35.
// - After leaving standby the serial port, converter and buffered switch are ready within typically 10 us.
// - After leaving standby the pump-fed power stages become ready after 560 to 960 us, typically 750.
// - The serial output is released while frame select is high and driven while it is low; the code drives it only while the port is also ready.
package spi_target_pkg;
  // ========================================================================
  // timebase
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FRAME_BITS = 24;
  // ========================================================================
  // timing figures in their own units and derived cycle counts
  localparam int unsigned SELECT_LOW_TIMEOUT_MS = 35;
  localparam int unsigned SELECT_LOW_TIMEOUT_CYC =
    SELECT_LOW_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned PORT_READY_US = 10;
  localparam int unsigned PORT_READY_CYC = PORT_READY_US * CLK_MHZ;
  localparam int unsigned PUMP_STAGE_READY_DELAY_US = 750;
  localparam int unsigned PUMP_STAGE_READY_DELAY_CYC =
    PUMP_STAGE_READY_DELAY_US * CLK_MHZ;
  localparam int unsigned MIN_SELECT_HIGH_TIME_US = 6;
  localparam int unsigned MIN_SELECT_HIGH_TIME_CYC =
    MIN_SELECT_HIGH_TIME_US * CLK_MHZ;
  localparam int unsigned MIN_SCLK_PERIOD_NS = 250;
  // ========================================================================
  // reset values
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 24'h000000;
  // ========================================================================
  // carrier for a committed command; one-hot power states
  typedef struct packed {
    logic valid;
    logic [FRAME_BITS-1:0] data;
  } command_t;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_WAKING = 3'b010,
    ST_ACTIVE = 3'b100
  } power_state_t;
endpackage

/* File: verification/spi_target_frame_timing_sva.sv */
// port assertions for the serial target block
`timescale 1ns/1ps
`default_nettype none
module spi_target_frame_timing_sva
#(
  parameter int unsigned TIMEOUT_CYC = 2000,
  parameter int unsigned PUMP_CYC = 3000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frameSelectLow,
  input wire logic serialClock,
  input wire logic wakeRequest,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire spi_target_pkg::command_t command,
  input wire logic selectTimeout,
  input wire logic portReady,
  input wire logic pumpStageReady
);
  import spi_target_pkg::*;
  int unsigned wakeCnt;
  int unsigned lowCnt;
  // ==========================================
  // counters stand in for very long repetitions
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wakeCnt <= '0;
      lowCnt <= '0;
    end
    else
    begin
      wakeCnt <= wakeRequest ? wakeCnt + 1 : '0;
      lowCnt <= !frameSelectLow && portReady ? lowCnt + 1 : '0;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_enable_on_fall: assert property
    ($fell(frameSelectLow) && portReady |=> serialOutEn) else $error("no en");
  a_release_high: assert property
    (frameSelectLow && $past(frameSelectLow) |-> !serialOutEn)
    else $error("driven while deselected");
  a_launch_fall: assert property
    (serialOutEn && $past(serialOutEn) && $changed(serialOut)
      |-> !$past(serialClock) && $past(serialClock, 2)) else $error("launch");
  a_cmd_at_rise: assert property
    (command.valid |-> $past(frameSelectLow) && !$past(frameSelectLow, 2))
    else $error("command off rise");
  a_timeout_count: assert property
    (selectTimeout |-> lowCnt inside {[TIMEOUT_CYC-1:TIMEOUT_CYC+2]})
    else $error("timeout count");
  a_port_delay: assert property
    ($rose(portReady) |-> wakeCnt inside {[PORT_READY_CYC-1:PORT_READY_CYC+2]})
    else $error("port delay");
  a_pump_delay: assert property
    ($rose(pumpStageReady) |-> wakeCnt inside {[PUMP_CYC-1:PUMP_CYC+2]})
    else $error("pump delay");
  a_standby_clear: assert property
    (!wakeRequest |=> !portReady && !pumpStageReady) else $error("standby");
endmodule
bind spi_target_frame_timing spi_target_frame_timing_sva #(
  .TIMEOUT_CYC(TIMEOUT_CYC), .PUMP_CYC(PUMP_CYC)) chk (.clk, .rst_n,
  .frameSelectLow, .serialClock, .wakeRequest, .serialOut, .serialOutEn,
  .command, .selectTimeout, .portReady, .pumpStageReady);
`default_nettype wire

/* File: verification/spi_ctrl_model.sv */
// controller model: mode 0 frames, reply capture
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_model
(
  input wire logic clk,
  input wire logic serialOut,
  input wire logic serialOutEn,
  output logic frameSelectLow,
  output logic serialClock,
  output logic serialIn
);
  import spi_target_pkg::*;
  // ==========================================
  // idle: deselected, clock parked low
  initial
  begin
    frameSelectLow = 1'b1;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end
  // n bits, half = clock half period in clk cycles
  task automatic frame(input logic [23:0] tx, input int n, input int half,
    output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge clk) frameSelectLow = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serialIn = tx[23-i];
      repeat (half) @(negedge clk);
      serialClock = 1'b1;
      // a released pin has no pull here, so it reads as the inverse of the
      // last driven bit: sampling while undriven shows up as a mismatch
      rx = {rx[22:0], serialOutEn ? serialOut : ~serialOut};
      repeat (half) @(negedge clk);
      serialClock = 1'b0;
    end
    repeat (half) @(negedge clk);
    frameSelectLow = 1'b1;
    repeat (MIN_SELECT_HIGH_TIME_CYC) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_spi_target_frame_timing.sv */
// bench for the serial target frame timing block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_target_frame_timing;
  import spi_target_pkg::*;
  logic clk, rst_n, wakeRequest, frameSelectLow, serialClock, serialIn;
  logic serialOut, serialOutEn, selectTimeout, portReady, pumpStageReady;
  logic [23:0] replyData, rx, lastCmd;
  command_t command;
  int err_count, checked, cmds, tos, i;
  logic [23:0] txRow [3] = '{24'hA5C3F0, 24'h000001, 24'hFFFFFF};
  logic [23:0] repRow [3] = '{24'h3C5A0F, 24'h800000, 24'h000000};
  // ==========================================
  // short counts keep the run brief
  spi_target_frame_timing #(.TIMEOUT_CYC(2000), .PUMP_CYC(3000)) dut (.clk,
    .rst_n, .frameSelectLow, .serialClock, .serialIn, .wakeRequest,
    .replyData, .serialOut, .serialOutEn, .command, .selectTimeout,
    .portReady, .pumpStageReady);
  spi_ctrl_model ctrl (.clk, .serialOut, .serialOutEn, .frameSelectLow,
    .serialClock, .serialIn);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulses tallied away from the active edge
  always @(negedge clk)
  begin
    if (command.valid === 1'b1) cmds++;
    if (command.valid === 1'b1) lastCmd = command.data;
    if (selectTimeout === 1'b1) tos++;
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    wakeRequest = 1'b0;
    replyData = 24'h000000;
    repeat (4) @(negedge clk);
    chk(24'({portReady, serialOutEn, command.valid}), 24'h0);
    rst_n = 1'b1;
    wakeRequest = 1'b1;
    for (i = 0; i < 1100 && portReady !== 1'b1; i++) @(negedge clk);
    chk(24'(i > 990 && i < 1010), 24'h1);
    if (i == 1100) conclude();
    chk(24'(pumpStageReady), 24'h0);
    for (i = 0; i < 3; i++)
    begin
      replyData = repRow[i];
      ctrl.frame(txRow[i], 24, 13, rx);
      chk(rx, repRow[i]);
      chk(lastCmd, txRow[i]);
      chk(24'(cmds), 24'(i + 1));
    end
    chk(24'(pumpStageReady), 24'h1);
    ctrl.frame(24'h123456, 23, 13, rx);
    chk(24'(cmds), 24'h3);
    ctrl.frame(24'h654321, 24, 50, rx);
    chk(24'(tos), 24'h1);
    chk(24'(cmds), 24'h3);
    wakeRequest = 1'b0;
    repeat (2) @(negedge clk);
    chk(24'({portReady, pumpStageReady}), 24'h0);
    conclude();
  end
endmodule
`default_nettype wire
